// ### bench/coprocessor_fault_recovery_properties.sv
module coprocessor_fault_recovery_properties (
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST,
  // command side
  input wire logic ENGINE_RESET_CONTROL,
  input wire logic CMD_VALID,
  input wire logic CACHE_CLEAR_OP,
  input wire logic CMD_READY,
  // engine outputs
  input wire logic [11:0] LIST_FILL_OFFSET,
  input wire logic [11:0] CMD_READ_PTR,
  input wire logic REPORT_WE,
  input wire logic [6:0] REPORT_ADDR,
  input wire logic [7:0] REPORT_DATA,
  input wire logic QUEUE_DRAINED_IRQ,
  input wire logic FAULTED,
  input wire logic [4:0] FAULT_CODE,
  input wire logic PCLK_DIV_CLEAR,
  input wire logic [23:0] BACK_COLOUR,
  input wire logic [4:0] SCRATCH_HANDLE,
  input wire logic [5:0] NUMBER_RADIX
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RST);
  // ==========
  // fault sequence
  a_fault_halts: assert property ($rose(FAULTED) |-> !CMD_READY)
    else $error("ready after fault");
  a_report_begins: assert property ($rose(FAULTED) |=> REPORT_WE && REPORT_ADDR == 7'h00)
    else $error("report late");
  a_report_steps: assert property (REPORT_WE && REPORT_ADDR != 7'h7f
    |=> REPORT_WE && REPORT_ADDR == $past(REPORT_ADDR) + 7'h01)
    else $error("report gap");
  a_text_start: assert property (REPORT_WE && REPORT_ADDR == 7'h00 |-> REPORT_DATA == 8'h45)
    else $error("text start");
  a_text_end: assert property (REPORT_WE && REPORT_ADDR == 7'h7f |-> REPORT_DATA == 8'h00)
    else $error("text end");
  a_irq_poison: assert property (QUEUE_DRAINED_IRQ
    |-> REPORT_WE && REPORT_ADDR == 7'h7f && CMD_READ_PTR == 12'hfff)
    else $error("irq or pointer");
  a_halt_holds: assert property (FAULTED && !ENGINE_RESET_CONTROL |=> FAULTED && !CMD_READY)
    else $error("halt lost");
  a_clear_busy: assert property (CMD_VALID && CMD_READY && CACHE_CLEAR_OP
    && LIST_FILL_OFFSET != 12'h000
    |=> (FAULTED && FAULT_CODE == 5'h0b) ##[0:140] PCLK_DIV_CLEAR)
    else $error("cache clear");
  a_held_defaults: assert property (ENGINE_RESET_CONTROL ##1 ENGINE_RESET_CONTROL
    |=> BACK_COLOUR == 24'h002040 && SCRATCH_HANDLE == 5'h0f
    && NUMBER_RADIX == 6'h0a && CMD_READ_PTR == 12'h000 && !CMD_READY)
    else $error("held defaults");
  c_irq: cover property (QUEUE_DRAINED_IRQ);
  c_pclk: cover property (PCLK_DIV_CLEAR);
  c_restart: cover property ($fell(ENGINE_RESET_CONTROL));
endmodule // coprocessor_fault_recovery_properties

// ### bench/coprocessor_fault_recovery_tb.sv
module coprocessor_fault_recovery_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic ENGINE_RESET_CONTROL, CMD_VALID, CMD_READY, COLD_START_OP, LIST_BEGIN_OP, SWAP_OP;
  logic BACK_COLOUR_OP, FORE_COLOUR_OP, HIGHLIGHT_COLOUR_OP, SCRATCH_HANDLE_OP;
  logic NUMBER_RADIX_OP, MEDIA_QUEUE_OP, CACHE_CLEAR_OP, HANDLE_USE, SIZE_USE, LIST_APPEND;
  logic IMAGE_DECODE_ERR, DECOMPRESS_ERR, BITMAP_FMT_UNKNOWN, FMT_BAD_CHAR, FMT_NO_SPEC;
  logic REPORT_WE, QUEUE_DRAINED_IRQ, FAULTED, PCLK_DIV_CLEAR;
  logic SPINNER_ACTIVE, TRACKERS_ACTIVE, IRQ_TIMER_ACTIVE;
  logic [7:0] CMD_OPCODE, REPORT_DATA;
  logic [23:0] COLOUR_ARG, BACK_COLOUR, FORE_COLOUR, HIGHLIGHT_COLOUR;
  logic signed [15:0] SIZE_ARG;
  logic [31:0] MEDIA_BASE_ARG, MEDIA_LEN_ARG, HANDLE_ARG, RADIX_ARG, MEDIA_BASE, MEDIA_LEN;
  logic [31:0] MATRIX_A, MATRIX_E, MATRIX_OTHERS, FONT_BUILTIN_MASK;
  logic [8:0] FMT_OUT_BYTES;
  logic [11:0] LIST_FILL_OFFSET, CMD_READ_PTR;
  logic [6:0] REPORT_ADDR;
  logic [4:0] FAULT_CODE, SCRATCH_HANDLE;
  logic [5:0] NUMBER_RADIX;
  logic [7:0] rep [128];
  logic irq_seen = 1'b0;
  logic pclk_seen = 1'b0;
  int nbytes = 0;
  int errors = 0;
  int cmp_count = 0;
  always #2 SYS_CLK = ~SYS_CLK;
  coprocessor_fault_recovery u_coprocessor_fault_recovery (
    .SYS_CLK, .RST, .ENGINE_RESET_CONTROL, .CMD_VALID, .CMD_OPCODE, .CMD_READY,
    .COLD_START_OP, .LIST_BEGIN_OP, .SWAP_OP, .BACK_COLOUR_OP, .FORE_COLOUR_OP,
    .HIGHLIGHT_COLOUR_OP, .COLOUR_ARG, .SCRATCH_HANDLE_OP, .NUMBER_RADIX_OP, .MEDIA_QUEUE_OP,
    .MEDIA_BASE_ARG, .MEDIA_LEN_ARG, .CACHE_CLEAR_OP, .HANDLE_USE, .SIZE_USE, .SIZE_ARG,
    .HANDLE_ARG, .RADIX_ARG, .IMAGE_DECODE_ERR, .DECOMPRESS_ERR, .BITMAP_FMT_UNKNOWN,
    .FMT_BAD_CHAR, .FMT_NO_SPEC, .FMT_OUT_BYTES, .LIST_APPEND, .LIST_FILL_OFFSET,
    .CMD_READ_PTR, .REPORT_WE, .REPORT_ADDR, .REPORT_DATA, .QUEUE_DRAINED_IRQ, .FAULTED,
    .FAULT_CODE, .PCLK_DIV_CLEAR, .BACK_COLOUR, .FORE_COLOUR, .HIGHLIGHT_COLOUR,
    .SCRATCH_HANDLE, .NUMBER_RADIX, .MEDIA_BASE, .MEDIA_LEN, .SPINNER_ACTIVE,
    .TRACKERS_ACTIVE, .IRQ_TIMER_ACTIVE, .MATRIX_A, .MATRIX_E, .MATRIX_OTHERS,
    .FONT_BUILTIN_MASK);
  host_model u_host_model (.SYS_CLK, .ENGINE_RESET_CONTROL);
  // ==========
  // report capture
  always @(posedge SYS_CLK)
  begin
    if (REPORT_WE === 1'b1)
    begin
      rep[REPORT_ADDR] <= REPORT_DATA;
      nbytes <= nbytes + 1;
    end
    if (QUEUE_DRAINED_IRQ === 1'b1)
      irq_seen <= 1'b1;
    if (PCLK_DIV_CLEAR === 1'b1)
      pclk_seen <= 1'b1;
  end
  // ==========
  // tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compares=%0d errors=%0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic idle();
    {CMD_VALID, COLD_START_OP, LIST_BEGIN_OP, SWAP_OP, BACK_COLOUR_OP, FORE_COLOUR_OP,
     HIGHLIGHT_COLOUR_OP, SCRATCH_HANDLE_OP, NUMBER_RADIX_OP, MEDIA_QUEUE_OP, CACHE_CLEAR_OP,
     HANDLE_USE, SIZE_USE, IMAGE_DECODE_ERR, DECOMPRESS_ERR, BITMAP_FMT_UNKNOWN,
     FMT_BAD_CHAR, FMT_NO_SPEC, LIST_APPEND} = '0;
    {CMD_OPCODE, COLOUR_ARG, MEDIA_BASE_ARG, MEDIA_LEN_ARG, HANDLE_ARG, FMT_OUT_BYTES} = '0;
    SIZE_ARG = 16'sh0001;
    RADIX_ARG = 32'h0000_000a;
  endtask
  task automatic wait_hi(input int w, input int lim);
    int n;
    n = 0;
    while (((w == 0) ? CMD_READY : irq_seen) !== 1'b1 && n < lim)
    begin
      @(negedge SYS_CLK);
      n++;
    end
    if (n == lim)
    begin
      errors++;
      give_verdict();
    end
  endtask
  task automatic issue();
    CMD_VALID = 1'b1;
    @(posedge SYS_CLK);
    @(negedge SYS_CLK);
    idle();
    @(negedge SYS_CLK);
  endtask
  task automatic fault(input int k);
    CMD_OPCODE = 8'h30 + 8'(k);
    HANDLE_ARG = 32'h0000_0020;
    RADIX_ARG = 32'h0000_0025;
    SIZE_ARG = 16'sh0000;
    case (k)
      1: LIST_APPEND = 1'b1;
      2: HANDLE_USE = 1'b1;
      3: NUMBER_RADIX_OP = 1'b1;
      4: SIZE_USE = 1'b1;
      5: FMT_OUT_BYTES = 9'h101;
      6: FMT_BAD_CHAR = 1'b1;
      7: FMT_NO_SPEC = 1'b1;
      8: IMAGE_DECODE_ERR = 1'b1;
      9: DECOMPRESS_ERR = 1'b1;
      10: BITMAP_FMT_UNKNOWN = 1'b1;
      default: CACHE_CLEAR_OP = 1'b1;
    endcase
    issue();
  endtask
  // ==========
  // main sequence
  initial
  begin
    idle();
    repeat (20) @(negedge SYS_CLK);
    RST = 1'b0;
    wait_hi(0, 10);
    check({BACK_COLOUR, FORE_COLOUR}, 48'h002040_003870);
    check(HIGHLIGHT_COLOUR, 24'hffffff);
    check(MEDIA_BASE | MEDIA_LEN, 32'h0);
    check({SCRATCH_HANDLE, NUMBER_RADIX, SPINNER_ACTIVE, TRACKERS_ACTIVE,
           IRQ_TIMER_ACTIVE}, {5'h0f, 6'h0a, 3'h0});
    check({MATRIX_A, MATRIX_E}, 64'h0001_0000_0001_0000);
    check({MATRIX_OTHERS, FONT_BUILTIN_MASK}, 64'h0000_0000_ffff_0000);
    for (int i = 0; i < 3; i++)
    begin
      {BACK_COLOUR_OP, FORE_COLOUR_OP, HIGHLIGHT_COLOUR_OP} = 3'h4 >> i;
      COLOUR_ARG = 24'h111111 * 24'(i + 1);
      issue();
      if (i == 0)
        check(FORE_COLOUR, 24'h003870);
    end
    check({BACK_COLOUR, FORE_COLOUR, HIGHLIGHT_COLOUR[15:0]}, 64'h111111_222222_3333);
    SCRATCH_HANDLE_OP = 1'b1;
    HANDLE_USE = 1'b1;
    HANDLE_ARG = 32'h0000_001f;
    issue();
    NUMBER_RADIX_OP = 1'b1;
    RADIX_ARG = 32'h0000_0024;
    issue();
    SIZE_USE = 1'b1;
    FMT_OUT_BYTES = 9'h100;
    MEDIA_QUEUE_OP = 1'b1;
    MEDIA_BASE_ARG = 32'h0000_1000;
    issue();
    check({FAULTED, SCRATCH_HANDLE, NUMBER_RADIX, MEDIA_BASE}, {1'b0, 5'h1f, 6'h24, 32'h1000});
    SWAP_OP = 1'b1;
    issue();
    LIST_BEGIN_OP = 1'b1;
    issue();
    check({BACK_COLOUR, NUMBER_RADIX}, {24'h111111, 6'h24});
    COLD_START_OP = 1'b1;
    issue();
    check({BACK_COLOUR, NUMBER_RADIX, MEDIA_BASE}, {24'h002040, 6'h0a, 32'h0});
    for (int k = 1; k < 12; k++)
    begin
      irq_seen = 1'b0;
      pclk_seen = 1'b0;
      nbytes = 0;
      if (k == 1 || k == 11)
      begin
        LIST_APPEND = 1'b1;
        CMD_VALID = 1'b1;
        repeat ((k == 1) ? 2048 : 1) @(posedge SYS_CLK);
        @(negedge SYS_CLK);
        idle();
        check({FAULTED, LIST_FILL_OFFSET}, (k == 1) ? 13'h0800 : 13'h0001);
      end
      fault(k);
      wait_hi(1, 200);
      check(FAULT_CODE, 64'(k));
      check({CMD_READ_PTR, 20'(nbytes)}, {12'hfff, 20'h80});
      check({rep[0], rep[1], rep[2], rep[3], rep[4], rep[127]}, {"ERROR", 8'h00});
      check(pclk_seen, k == 11);
      BACK_COLOUR_OP = 1'b1;
      COLOUR_ARG = 24'habcdef;
      CMD_VALID = 1'b1;
      repeat (3) @(negedge SYS_CLK);
      idle();
      check({BACK_COLOUR, CMD_READ_PTR}, {24'h002040, 12'hfff});
      u_host_model.recover();
      wait_hi(0, 20);
      check({FAULTED, LIST_FILL_OFFSET, CMD_READ_PTR}, 25'h0);
    end
    issue();
    check(CMD_READ_PTR, 12'h004);
    give_verdict();
  end
endmodule // coprocessor_fault_recovery_tb
bind coprocessor_fault_recovery coprocessor_fault_recovery_properties
  u_coprocessor_fault_recovery_properties (
  .SYS_CLK, .RST, .ENGINE_RESET_CONTROL, .CMD_VALID, .CACHE_CLEAR_OP, .CMD_READY,
  .LIST_FILL_OFFSET, .CMD_READ_PTR, .REPORT_WE, .REPORT_ADDR, .REPORT_DATA,
  .QUEUE_DRAINED_IRQ, .FAULTED, .FAULT_CODE, .PCLK_DIV_CLEAR, .BACK_COLOUR,
  .SCRATCH_HANDLE, .NUMBER_RADIX);

// ### bench/host_model.sv
module host_model (
  // clock
  input wire logic SYS_CLK,
  // engine reset control
  output logic ENGINE_RESET_CONTROL
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] engine_patch_pointer = 32'h0000_0100;
  logic [11:0] cmd_write_ptr = 12'h000;
  logic flash_attached = 1'b0;
  logic flash_fast = 1'b0;
  initial ENGINE_RESET_CONTROL = 1'b0;
  // ==========
  // recovery sequence
  task automatic recover();
    logic [31:0] saved;
    saved = engine_patch_pointer;
    @(negedge SYS_CLK);
    ENGINE_RESET_CONTROL = 1'b1;
    cmd_write_ptr = 12'h000;
    repeat (4) @(negedge SYS_CLK);
    ENGINE_RESET_CONTROL = 1'b0;
    engine_patch_pointer = saved;
    flash_attached = 1'b1;
    flash_fast = flash_attached;
  endtask
endmodule // host_model

// ### hw/coprocessor_fault_recovery.v
// What this block does
// RL1: fault on undecodable image or bad stream
// RL2: fault when list exceeds 2048 entries
// RL3: write 128-byte diagnostic at report area
// RL4: load read pointer with 0xfff
// RL5: refuse commands from the fault on, raise drained interrupt with last report byte
// RL6: text starts ERROR, names fault, zero-terminated
// RL7: fault on handle outside 0 to 31
// RL8: fault on radix outside 2 to 36
// RL9: fault on zero or negative size
// RL10: fault when formatted text exceeds 256 bytes
// RL11: fault on bad format character or specifier
// RL12: fault on unknown bitmap format code
// RL13: cache clear on busy list faults, zeroes divisor
// RL14: host saves and restores patch pointer
// RL15: reset control 1 holds; host clears pointers
// RL16: reset control 0 releases and restarts
// RL17: host reattaches flash, then fast mode
// RL18: defaults on reset and cold start only; code also loads them in ST_HELD while reset control holds
// RL19: colour defaults, each set by own command
// RL20: media queue defaults to zero base, length
// RL21: scratch 15, radix 10, timers inactive
// RL22: identity matrix, fonts 16-31 built-in
`include "fault_recovery_defines.vh"
module coprocessor_fault_recovery (
  // clock and reset
  input wire SYS_CLK,
  input wire RST,
  // engine reset control from host register
  input wire ENGINE_RESET_CONTROL,
  // command issue, same clock
  input wire CMD_VALID,
  input wire [7:0] CMD_OPCODE,
  output reg CMD_READY,
  // command operations
  input wire COLD_START_OP,
  input wire LIST_BEGIN_OP,
  input wire SWAP_OP,
  input wire BACK_COLOUR_OP,
  input wire FORE_COLOUR_OP,
  input wire HIGHLIGHT_COLOUR_OP,
  input wire [23:0] COLOUR_ARG,
  input wire SCRATCH_HANDLE_OP,
  input wire NUMBER_RADIX_OP,
  input wire MEDIA_QUEUE_OP,
  input wire [31:0] MEDIA_BASE_ARG,
  input wire [31:0] MEDIA_LEN_ARG,
  input wire CACHE_CLEAR_OP,
  input wire HANDLE_USE,
  input wire SIZE_USE,
  input wire signed [15:0] SIZE_ARG,
  input wire [31:0] HANDLE_ARG,
  input wire [31:0] RADIX_ARG,
  // error reports from decoders and formatter
  input wire IMAGE_DECODE_ERR,
  input wire DECOMPRESS_ERR,
  input wire BITMAP_FMT_UNKNOWN,
  input wire FMT_BAD_CHAR,
  input wire FMT_NO_SPEC,
  input wire [8:0] FMT_OUT_BYTES,
  input wire LIST_APPEND,
  // list fill offset register
  output reg [11:0] LIST_FILL_OFFSET,
  // command read pointer
  output reg [11:0] CMD_READ_PTR,
  // report memory write port
  output reg REPORT_WE,
  output reg [6:0] REPORT_ADDR,
  output reg [7:0] REPORT_DATA,
  // interrupt and state
  output reg QUEUE_DRAINED_IRQ,
  output reg FAULTED,
  output reg [4:0] FAULT_CODE,
  output reg PCLK_DIV_CLEAR,
  // drawing state
  output reg [23:0] BACK_COLOUR,
  output reg [23:0] FORE_COLOUR,
  output reg [23:0] HIGHLIGHT_COLOUR,
  output reg [4:0] SCRATCH_HANDLE,
  output reg [5:0] NUMBER_RADIX,
  output reg [31:0] MEDIA_BASE,
  output reg [31:0] MEDIA_LEN,
  output reg SPINNER_ACTIVE,
  output reg TRACKERS_ACTIVE,
  output reg IRQ_TIMER_ACTIVE,
  output reg [31:0] MATRIX_A,
  output reg [31:0] MATRIX_E,
  output reg [31:0] MATRIX_OTHERS,
  output reg [31:0] FONT_BUILTIN_MASK
);
  localparam [1:0] ST_RUN = 2'h0;
  localparam [1:0] ST_REPORT = 2'h1;
  localparam [1:0] ST_HALT = 2'h2;
  localparam [1:0] ST_HELD = 2'h3;

  // =========================================
  // reset control synchroniser not needed: same clock domain register
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [4:0] code_ff;
  reg [7:0] op_ff;
  reg [6:0] idx_ff;
  wire [7:0] rom_byte;
  reg [4:0] detect;
  wire take;
  wire defaults;

  assign take = CMD_VALID && (state_ff == ST_RUN);
  assign defaults = RST || (state_ff == ST_HELD) || (take && COLD_START_OP); // RL18

  fault_text_rom u_text (
    .code(code_ff),
    .idx(idx_ff),
    .op_lo(op_ff),
    .text_byte(rom_byte)
  );

  // =========================================
  // fault detection, lowest code wins
  always @*
  begin
    detect = `FLT_NONE;
    if (take)
    begin
      if (LIST_APPEND && (LIST_FILL_OFFSET >= `LIST_MAX_ENTRIES))
        detect = `FLT_LIST_OVERFLOW; // RL2
      else if (HANDLE_USE && (HANDLE_ARG > {26'h0, `HANDLE_MAX}))
        detect = `FLT_BAD_HANDLE; // RL7
      else if (NUMBER_RADIX_OP && ((RADIX_ARG < {26'h0, `RADIX_MIN}) ||
               (RADIX_ARG > {26'h0, `RADIX_MAX})))
        detect = `FLT_BAD_BASE; // RL8
      else if (SIZE_USE && (SIZE_ARG <= 16'sh0000))
        detect = `FLT_BAD_SIZE; // RL9
      else if (FMT_OUT_BYTES > `FMT_MAX_BYTES)
        detect = `FLT_FMT_OVERFLOW; // RL10
      else if (FMT_BAD_CHAR)
        detect = `FLT_FMT_CHAR; // RL11
      else if (FMT_NO_SPEC)
        detect = `FLT_FMT_STRING; // RL11
      else if (IMAGE_DECODE_ERR)
        detect = `FLT_BAD_IMAGE; // RL1
      else if (DECOMPRESS_ERR)
        detect = `FLT_BAD_DEFLATE; // RL1
      else if (BITMAP_FMT_UNKNOWN)
        detect = `FLT_BITMAP_FMT; // RL12
      else if (CACHE_CLEAR_OP && (LIST_FILL_OFFSET != 12'h000))
        detect = `FLT_LIST_NOT_EMPTY; // RL13
    end
  end

  // =========================================
  // fault sequencer
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN:
        if (ENGINE_RESET_CONTROL)
          nxt_state = ST_HELD; // RL15
        else if (detect != `FLT_NONE)
          nxt_state = ST_REPORT;
      ST_REPORT:
        if (idx_ff == `REPORT_LAST)
          nxt_state = ST_HALT; // RL3
      ST_HALT:
        if (ENGINE_RESET_CONTROL)
          nxt_state = ST_HELD; // RL5
      ST_HELD:
        if (!ENGINE_RESET_CONTROL)
          nxt_state = ST_RUN; // RL16
      default:
        nxt_state = ST_HELD;
    endcase
  end

  always @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      state_ff <= ST_RUN;
      code_ff <= `FLT_NONE;
      op_ff <= 8'h00;
      idx_ff <= 7'h00;
      CMD_READY <= 1'b0;
      CMD_READ_PTR <= 12'h000;
      LIST_FILL_OFFSET <= 12'h000;
      REPORT_WE <= 1'b0;
      REPORT_ADDR <= 7'h00;
      REPORT_DATA <= 8'h00;
      QUEUE_DRAINED_IRQ <= 1'b0;
      FAULTED <= 1'b0;
      FAULT_CODE <= `FLT_NONE;
      PCLK_DIV_CLEAR <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      CMD_READY <= (nxt_state == ST_RUN); // RL5
      REPORT_WE <= 1'b0;
      QUEUE_DRAINED_IRQ <= 1'b0;
      PCLK_DIV_CLEAR <= 1'b0;
      if (nxt_state == ST_HELD)
      begin
        // host clears the pointers while held; mirror that here
        CMD_READ_PTR <= 12'h000; // RL15
        LIST_FILL_OFFSET <= 12'h000; // RL15
        FAULTED <= 1'b0;
        FAULT_CODE <= `FLT_NONE;
        idx_ff <= 7'h00;
      end
      else if (state_ff == ST_RUN && detect != `FLT_NONE)
      begin
        code_ff <= detect;
        op_ff <= CMD_OPCODE;
        idx_ff <= 7'h00;
        FAULTED <= 1'b1;
        FAULT_CODE <= detect;
        if (detect == `FLT_LIST_NOT_EMPTY)
          PCLK_DIV_CLEAR <= 1'b1; // RL13
      end
      else if (take)
      begin
        CMD_READ_PTR <= CMD_READ_PTR + 12'h004;
        if (LIST_BEGIN_OP)
          LIST_FILL_OFFSET <= 12'h000;
        else if (LIST_APPEND)
          LIST_FILL_OFFSET <= LIST_FILL_OFFSET + 12'h001;
      end
      else if (state_ff == ST_REPORT)
      begin
        REPORT_WE <= 1'b1; // RL3
        REPORT_ADDR <= idx_ff; // RL3
        REPORT_DATA <= rom_byte; // RL6
        idx_ff <= idx_ff + 7'h01;
        if (idx_ff == `REPORT_LAST)
        begin
          CMD_READ_PTR <= `READ_PTR_POISON; // RL4
          QUEUE_DRAINED_IRQ <= 1'b1; // RL5
        end
      end
    end
  end

  // =========================================
  // persistent drawing state
  always @(posedge SYS_CLK)
  begin
    if (defaults)
    begin
      BACK_COLOUR <= `BACK_COLOUR_RST; // RL19
      FORE_COLOUR <= `FORE_COLOUR_RST; // RL19
      HIGHLIGHT_COLOUR <= `HIGHLIGHT_RST; // RL19
      SCRATCH_HANDLE <= `SCRATCH_RST; // RL21
      NUMBER_RADIX <= `RADIX_RST; // RL21
      MEDIA_BASE <= `MEDIA_BASE_RST; // RL20
      MEDIA_LEN <= `MEDIA_LEN_RST; // RL20
      SPINNER_ACTIVE <= 1'b0; // RL21
      TRACKERS_ACTIVE <= 1'b0; // RL21
      IRQ_TIMER_ACTIVE <= 1'b0; // RL21
      MATRIX_A <= `MATRIX_ONE; // RL22
      MATRIX_E <= `MATRIX_ONE; // RL22
      MATRIX_OTHERS <= `MATRIX_ZERO; // RL22
      FONT_BUILTIN_MASK <= `FONT_MASK_RST; // RL22
    end
    else if (take && detect == `FLT_NONE)
    begin
      // list begin and swap leave this state alone
      if (BACK_COLOUR_OP)
        BACK_COLOUR <= COLOUR_ARG; // RL19
      if (FORE_COLOUR_OP)
        FORE_COLOUR <= COLOUR_ARG; // RL19
      if (HIGHLIGHT_COLOUR_OP)
        HIGHLIGHT_COLOUR <= COLOUR_ARG; // RL19
      if (SCRATCH_HANDLE_OP)
        SCRATCH_HANDLE <= HANDLE_ARG[4:0];
      if (NUMBER_RADIX_OP)
        NUMBER_RADIX <= RADIX_ARG[5:0];
      if (MEDIA_QUEUE_OP)
      begin
        MEDIA_BASE <= MEDIA_BASE_ARG;
        MEDIA_LEN <= MEDIA_LEN_ARG;
      end
    end
  end
endmodule // coprocessor_fault_recovery

// ### hw/fault_recovery_defines.vh
`ifndef FAULT_RECOVERY_DEFINES_VH
`define FAULT_RECOVERY_DEFINES_VH
// =========================================
// fault codes
`define FLT_NONE 5'h00
`define FLT_LIST_OVERFLOW 5'h01
`define FLT_BAD_HANDLE 5'h02
`define FLT_BAD_BASE 5'h03
`define FLT_BAD_SIZE 5'h04
`define FLT_FMT_OVERFLOW 5'h05
`define FLT_FMT_CHAR 5'h06
`define FLT_FMT_STRING 5'h07
`define FLT_BAD_IMAGE 5'h08
`define FLT_BAD_DEFLATE 5'h09
`define FLT_BITMAP_FMT 5'h0a
`define FLT_LIST_NOT_EMPTY 5'h0b
// =========================================
// limits and layout
`define LIST_MAX_ENTRIES 12'h800
`define FMT_MAX_BYTES 9'h100
`define REPORT_BYTES 8'h80
`define REPORT_LAST 7'h7f
`define READ_PTR_POISON 12'hfff
`define HANDLE_MAX 6'h1f
`define RADIX_MIN 6'h02
`define RADIX_MAX 6'h24
// =========================================
// drawing state defaults
`define BACK_COLOUR_RST 24'h002040
`define FORE_COLOUR_RST 24'h003870
`define HIGHLIGHT_RST 24'hffffff
`define SCRATCH_RST 5'h0f
`define RADIX_RST 6'h0a
`define MEDIA_BASE_RST 32'h0000_0000
`define MEDIA_LEN_RST 32'h0000_0000
`define MATRIX_ONE 32'h0001_0000
`define MATRIX_ZERO 32'h0000_0000
`define FONT_UNDEF 32'hffff_ffff
`define ROM_FONT_SLOT_MIN 5'h10
`define FONT_MASK_RST 32'hffff_0000
`endif

// ### hw/fault_text_rom.v
`include "fault_recovery_defines.vh"
// =========================================
// diagnostic text byte lookup
module fault_text_rom (
  // lookup
  input wire [4:0] code,
  input wire [6:0] idx,
  input wire [7:0] op_lo,
  output reg [7:0] text_byte
);
  reg [255:0] msg;
  reg [6:0] mlen;
  reg [55:0] head;
  reg [79:0] mid;
  always @*
  begin
    msg = 256'h0;
    mlen = 7'h00;
    head = "ERROR: ";
    mid = " in cmd 0x";
    case (code)
      `FLT_LIST_OVERFLOW: begin msg = "display list overflow"; mlen = 7'd21; end
      `FLT_BAD_HANDLE: begin msg = "illegal font or bitmap handle"; mlen = 7'd29; end
      `FLT_BAD_BASE: begin msg = "invalid base"; mlen = 7'd12; end
      `FLT_BAD_SIZE: begin msg = "invalid size"; mlen = 7'd12; end
      `FLT_FMT_OVERFLOW: begin msg = "format buffer overflow"; mlen = 7'd22; end
      `FLT_FMT_CHAR: begin msg = "invalid format character"; mlen = 7'd24; end
      `FLT_FMT_STRING: begin msg = "invalid format string"; mlen = 7'd21; end
      `FLT_BAD_IMAGE: begin msg = "image type not recognized"; mlen = 7'd25; end
      `FLT_BAD_DEFLATE: begin msg = "corrupted DEFLATE data"; mlen = 7'd22; end
      `FLT_BITMAP_FMT: begin msg = "unknown bitmap format"; mlen = 7'd21; end
      `FLT_LIST_NOT_EMPTY: begin msg = "display list must be empty"; mlen = 7'd26; end
      default: begin msg = "unknown"; mlen = 7'd7; end
    endcase
    // layout: "ERROR: " msg " in cmd 0x" hh
    text_byte = 8'h00;
    if (idx < 7'd7)
      text_byte = head[((7'd6 - idx) * 8) +: 8]; // RL6
    else if (idx < 7'd7 + mlen)
      text_byte = msg[((mlen - 7'd1 - (idx - 7'd7)) * 8) +: 8]; // RL6
    else if (idx < 7'd7 + mlen + 7'd10)
      text_byte = mid[((7'd9 - (idx - 7'd7 - mlen)) * 8) +: 8];
    else if (idx == 7'd17 + mlen)
      text_byte = hex_char(op_lo[7:4]); // RL6
    else if (idx == 7'd18 + mlen)
      text_byte = hex_char(op_lo[3:0]);
  end
  function [7:0] hex_char;
    input [3:0] n;
    begin
      hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
    end
  endfunction
endmodule // fault_text_rom
